// File: dv/cic_host.sv
// Host model issuing PCI interrupt-acknowledge requests
`timescale 1ns/10ps
module cic_host (
	input  wire logic       clk_in,    // System clock
	input  wire logic       trdy_in,   // Target ready
	input  wire logic [7:0] vector_in, // Vector from the block
	output logic            iack_out   // Acknowledge request, level
);
	initial iack_out = 1'b0;
	// Request after gap cycles, hold until ready, give up if none
	task automatic ack(input int gap, output logic [7:0] v, output logic got);
		got = 1'b0;
		v = 8'h00;
		repeat (gap + 1) @(posedge clk_in);
		iack_out <= 1'b1;
		for (int i = 0; i < 8 && !got; i++) begin
			@(posedge clk_in);
			if (trdy_in === 1'b1) begin
				got = 1'b1;
				v = vector_in;
			end
		end
		iack_out <= 1'b0; // Dropped at the ready edge so no retake
	endtask
endmodule

// File: dv/cic_sva.sv
// Port-level checks for the cascaded interrupt controller
`timescale 1ns/10ps
module cic_sva (
	input wire logic       clk_sys_in,        // System clock
	input wire logic       reset_in,          // Synchronous reset
	input wire logic       io_rd_in,          // I/O read strobe
	input wire logic [7:0] io_rdata_out,      // I/O read data
	input wire logic       cfg_rd_in,         // Config read strobe
	input wire logic [7:0] cfg_index_in,      // Config index
	input wire logic [7:0] cfg_rdata_out,     // Config read data
	input wire logic       pci_iack_hold_out, // Bus hold
	input wire logic       pci_trdy_out,      // Target ready
	input wire logic [7:0] pci_vector_out     // Returned vector
);
	// One clock domain, so one default clock and reset
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (reset_in);
	a_hold_to_ready: assert property ($rose(pci_iack_hold_out) |-> ##2 pci_trdy_out)
		else $error("ready not two cycles after hold");
	a_hold_span: assert property ($rose(pci_iack_hold_out) |-> pci_iack_hold_out[*3] ##1 !pci_iack_hold_out)
		else $error("hold not three cycles long");
	a_ready_pulse: assert property (pci_trdy_out |=> !pci_trdy_out)
		else $error("ready longer than one cycle");
	a_ready_in_hold: assert property (pci_trdy_out |-> pci_iack_hold_out)
		else $error("ready outside hold");
	a_vector_kept: assert property (!pci_trdy_out |-> $stable(pci_vector_out))
		else $error("vector moved without ready");
	a_io_idle_zero: assert property (!io_rd_in |=> io_rdata_out == 8'h00)
		else $error("io data without read");
	a_cfg_idle_zero: assert property (!cfg_rd_in |=> cfg_rdata_out == 8'h00)
		else $error("config data without read");
	// Only two indexes are mapped; all others read zero
	a_cfg_unmapped: assert property (cfg_rd_in && cfg_index_in != 8'h40 && cfg_index_in != 8'hB9
		|=> cfg_rdata_out == 8'h00)
		else $error("unmapped index not zero");
endmodule

// File: dv/cic_top_tb.sv
// Self-checking bench for the cascaded interrupt controller
`timescale 1ns/10ps
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin num_errors++; $display("unexpected %s exp %h seen %h", n, e, a); end end
module cic_top_tb;
	logic        clk = 1'b0;       // System clock
	logic        rst = 1'b1;       // Synchronous reset
	logic [15:0] ext = 16'h0000;   // External request pins
	logic        cop = 1'b0;       // Coprocessor request
	logic        tmr = 1'b0;       // Timer zero output
	logic        io_wr = 1'b0;     // Bus strobes
	logic        io_rd = 1'b0;
	logic        cfg_wr = 1'b0;
	logic        cfg_rd = 1'b0;
	logic [15:0] addr = 16'h0000;  // Shared address, low byte is config index
	logic [7:0]  wdata = 8'h00;    // Shared write data
	logic [3:0]  pci_n = 4'hF;     // PCI lines, active low
	logic [15:0] tgt = 16'h0000;   // PCI target codes
	logic        rtc_n = 1'b1;     // Clock request, active low
	logic [7:0]  rd;               // Last value read
	logic        iack, hold, trdy, irq;
	logic [7:0]  vec, io_rdata, cfg_rdata;
	int          num_errors = 0;
	int          check_count = 0;
	int          cyc = 0;          // Hang limit counter
	always #5 clk = ~clk;
	cic_top cic_top_inst (.clk_sys_in(clk), .reset_in(rst), .ext_irq_in(ext), .rtc_irq_n_in(rtc_n),
		.coproc_irq_in(cop), .timer_zero_output_in(tmr), .pci_int_n_in(pci_n), .pci_target_in(tgt),
		.io_wr_in(io_wr), .io_rd_in(io_rd), .io_addr_in(addr), .io_wdata_in(wdata), .io_rdata_out(io_rdata),
		.cfg_wr_in(cfg_wr), .cfg_rd_in(cfg_rd), .cfg_index_in(addr[7:0]), .cfg_wdata_in(wdata),
		.cfg_rdata_out(cfg_rdata), .pci_iack_in(iack), .pci_iack_hold_out(hold), .pci_trdy_out(trdy),
		.pci_vector_out(vec), .cpu_interrupt_request_out(irq));
	cic_host cic_host_inst (.clk_in(clk), .trdy_in(trdy), .vector_in(vec), .iack_out(iack));
	// One-cycle access on either bus; read data taken mid-cycle, return on a rising edge
	task automatic bus(input logic c, input logic w, input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		{cfg_wr, cfg_rd, io_wr, io_rd} <= {c & w, c & ~w, ~c & w, ~c & ~w};
		addr <= a;
		wdata <= d;
		@(posedge clk);
		{cfg_wr, cfg_rd, io_wr, io_rd} <= 4'h0;
		@(negedge clk) rd = c ? cfg_rdata : io_rdata; // While the answer stands
		@(posedge clk);
	endtask
	task automatic rdchk(input logic c, input logic [15:0] a, input logic [7:0] e, input string n);
		bus(c, 1'b0, a, 8'h00);
		`CHK(n, e, rd)
	endtask
	// Thirteen reads: the full list, then the wrap to entry zero
	task automatic shadow_chk(input logic [95:0] e);
		for (int k = 0; k < 13; k++) rdchk(1'b1, 16'h00B9, e[95 - 8 * (k % 12) -: 8], "shadow");
	endtask
	// Wait for the processor request, then run one acknowledge
	task automatic ack_chk(input logic [7:0] e, input logic en, input int gap);
		logic [7:0] v;
		logic       got;
		for (int i = 0; i < 12 && irq !== 1'b1; i++) @(posedge clk);
		`CHK("cpu irq", 1'b1, irq)
		cic_host_inst.ack(gap, v, got);
		`CHK("ready seen", en, got)
		if (en) `CHK("vector", e, v)
	endtask
	// Non-specific end of interrupt to both controllers, slave first
	task automatic eoi();
		bus(1'b0, 1'b1, 16'h00A0, 8'h20);
		bus(1'b0, 1'b1, 16'h0020, 8'h20);
	endtask
	task automatic t_reset();
		rdchk(1'b1, 16'h0040, 8'h89, "fc1 reset");
		rdchk(1'b1, 16'h0041, 8'h00, "unmapped");
		shadow_chk(96'h00000000004A_00000000004A);
	endtask
	// Mask refused before init; four words per controller, then mask accepted
	task automatic t_init();
		logic [63:0] w;
		w = 64'h110804E1_117002E1;
		bus(1'b0, 1'b1, 16'h0021, 8'h55);
		rdchk(1'b0, 16'h0021, 8'h00, "mask pre init");
		for (int k = 0; k < 8; k++) bus(1'b0, 1'b1, ((k < 4) ? 16'h0020 : 16'h00A0) | 16'((k % 4) != 0), w[63 - 8 * k -: 8]);
		bus(1'b0, 1'b1, 16'h0021, 8'h80);
		rdchk(1'b0, 16'h0021, 8'h80, "mask post init");
		bus(1'b0, 1'b1, 16'h04D0, 8'hFF);
		bus(1'b0, 1'b1, 16'h04D1, 8'hFF);
		rdchk(1'b0, 16'h04D0, 8'hFA, "sense lo");
		rdchk(1'b0, 16'h04D1, 8'hDE, "sense hi");
	endtask
	// Level input three, with acknowledge response off then on
	task automatic t_ack();
		ext[3] <= 1'b1;
		bus(1'b1, 1'b1, 16'h0040, 8'h09);
		rdchk(1'b1, 16'h0040, 8'h09, "fc1");
		ack_chk(8'h00, 1'b0, 0);
		bus(1'b1, 1'b1, 16'h0040, 8'h89);
		ack_chk(8'h0B, 1'b1, 0);
		ext[3] <= 1'b0;
		bus(1'b0, 1'b1, 16'h0020, 8'h20); // End of interrupt
		bus(1'b0, 1'b1, 16'h0020, 8'h0B); // Even port reads in-service
		rdchk(1'b0, 16'h0020, 8'h00, "isr cleared");
	endtask
	// Coprocessor on slave input five reaches the host through master input two
	task automatic t_cascade();
		cop <= 1'b1;
		ack_chk(8'h75, 1'b1, 0);
		rdchk(1'b0, 16'h0020, 8'h04, "master isr");
		cop <= 1'b0;
		eoi();
	endtask
	// Timer edge on master input zero, with a slow host
	task automatic t_timer();
		tmr <= 1'b1;
		ack_chk(8'h08, 1'b1, 3);
		tmr <= 1'b0;
		eoi();
	endtask
	// One PCI line steered to slave input two, then the clock request on slave input zero
	task automatic t_pci();
		tgt <= 16'h000A;
		pci_n <= 4'hE;
		ack_chk(8'h72, 1'b1, 0);
		pci_n <= 4'hF;
		rtc_n <= 1'b0;
		eoi();
		ack_chk(8'h70, 1'b1, 0);
		rtc_n <= 1'b1;
		eoi();
	endtask
	// Global level mode on the slave turns the coprocessor edge input into a level
	task automatic t_level();
		logic [31:0] w;
		w = 32'h197002E1;
		for (int k = 0; k < 4; k++) bus(1'b0, 1'b1, 16'h00A0 | 16'(k != 0), w[31 - 8 * k -: 8]);
		cop <= 1'b1;
		ack_chk(8'h75, 1'b1, 0);
		eoi();
		ack_chk(8'h75, 1'b1, 0);
		cop <= 1'b0;
		eoi();
	endtask
	// Operation word two restored the way software does it, then the full list
	task automatic t_shadow();
		bus(1'b0, 1'b1, 16'h00A0, 8'h00);
		bus(1'b0, 1'b1, 16'h00A0, 8'hC0);
		bus(1'b1, 1'b1, 16'h00B9, 8'hFF);
		shadow_chk(96'h11080401004B_19700201804A);
	endtask
	task automatic results();
		$display("errors %0d checks %0d", num_errors, check_count);
		if (num_errors == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// Hang limit well above the expected run
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			num_errors++;
			results();
		end
	end
	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_init();
		t_ack();
		t_cascade();
		t_timer();
		t_pci();
		t_level();
		t_shadow();
		results();
	end
endmodule
bind cic_top cic_sva cic_sva_inst (.clk_sys_in, .reset_in, .io_rd_in, .io_rdata_out, .cfg_rd_in, .cfg_index_in,
	.cfg_rdata_out, .pci_iack_hold_out, .pci_trdy_out, .pci_vector_out);

// File: pkg/cic_pkg.sv
// Constants, field layouts and types for the cascaded interrupt controller
package cic_pkg;
	localparam logic [15:0] MASTER_PORT     = 16'h0020;   // Master command/mask port pair
	localparam logic [15:0] SLAVE_PORT      = 16'h00A0;   // Slave command/mask port pair
	localparam logic [15:0] SENSE_LO_PORT   = 16'h04D0;   // Edge/level select, inputs 7..0
	localparam logic [15:0] SENSE_HI_PORT   = 16'h04D1;   // Edge/level select, inputs 15..8
	localparam logic [7:0]  SENSE_LO_MASK   = 8'hFA;      // Inputs 0 and 2 have select bits fixed zero
	localparam logic [7:0]  SENSE_HI_MASK   = 8'hDE;      // Inputs 8 and 13 have select bits fixed zero
	localparam logic [7:0]  FUNC_CTL1_IDX   = 8'h40;      // Function control register 1
	localparam logic [7:0]  FUNC_CTL1_RST   = 8'h89;      // Its reset value
	localparam int          IACK_EN_BIT     = 7;          // Acknowledge response enable bit
	localparam logic [7:0]  SHADOW_IDX      = 8'hB9;      // Shadow read port
	localparam logic [3:0]  SHADOW_LAST     = 4'hB;       // Twelve entries, 0..11
	localparam logic [3:0]  SHADOW_PER_CTL  = 4'h6;       // Entries per controller
	localparam logic [7:0]  INIT_WORD_FOUR_READ_MASK  = 8'h1F;      // Bits 7..5 read zero
	localparam logic [7:0]  OPERATION_WORD_TWO_READ_MASK  = 8'h87;      // Bits 6..3 read zero
	localparam logic [7:0]  OPERATION_WORD_THREE_READ_MASK  = 8'h27;      // Bits 7 and 4 read zero
	localparam logic [7:0]  OPERATION_WORD_THREE_READ_ONES  = 8'h48;      // Bits 6 and 3 read one
	localparam logic [7:0]  OPERATION_WORD_THREE_RESET      = 8'h0A;      // Read request register by default
	localparam logic [2:0]  PRIO_RESET      = 3'h7;       // Input 7 lowest, input 0 highest
	localparam logic [7:0]  SPURIOUS_IDX    = 8'h07;      // Vector offset with nothing pending
	localparam int          CASCADE_INPUT   = 2;          // Master input fed by the slave
	localparam int          INIT_LEVEL_BIT  = 3;          // Global level mode in word one
	localparam int          INIT_SINGLE_BIT = 1;          // Single controller, no word three
	localparam int          INIT_IC4_BIT    = 0;          // Word four follows
	localparam int          AUTO_EOI_BIT    = 1;          // Automatic end of interrupt

	// Initialization step: which word the odd port expects next
	typedef enum logic [1:0] {
		STEP_NONE  = 2'b00,
		STEP_WORD2 = 2'b01,
		STEP_WORD3 = 2'b10,
		STEP_WORD4 = 2'b11
	} cic_step_t;

	// Acknowledge sequencer states
	typedef enum logic [1:0] {
		ACK_IDLE  = 2'b00,
		ACK_FIRST = 2'b01,
		ACK_SECND = 2'b10,
		ACK_DONE  = 2'b11
	} cic_ack_t;

	// State of one controller
	typedef struct packed {
		logic [7:0] init_word_one;
		logic [7:0] init_word_two;
		logic [7:0] init_word_three;
		logic [7:0] init_word_four;
		logic [7:0] operation_word_two;
		logic [7:0] operation_word_three;
		logic [7:0] imr;
		logic [7:0] irr;
		logic [7:0] isr;
		logic [7:0] prev;
		logic [2:0] prio;
		cic_step_t  step;
		logic       ready;
	} cic_ctl_t;
endpackage

// File: src/cic_top.sv
// Cascaded master/slave interrupt controller with acknowledge sequencer and shadow port
`timescale 1ns/10ps

// Summary of operation
// - Master and slave controllers, no special nesting
// - Slave interrupt drives master input two
// - Timer zero output drives master input zero
// - Input eight active-low clock, thirteen coprocessor
// - Twelve remaining inputs come from external pins
// - Per-input level select in two I/O registers
// - Unmasked request above in-service raises processor interrupt once initialized
// - First acknowledge resolves master or slave source
// - Second acknowledge forms highest priority vector
// - Acknowledge response enabled by control bit seven
// - Bus acknowledge runs both cycles, then ready
// - Word one starts sequence of words two-four
// - Operation words accepted only after initialization
// - Eight-bit shadow port, pointer advances per read
// - Shadow write returns pointer to first entry
// - Shadow entries keep last written word values, except word one resets operation word three
// - Order: master words then slave words, twelve
// - Shadow reserved bits read fixed zeros or ones
// - Active-low PCI lines inverted before controllers
// - Global level mode overrides per-input select
module cic_top (
	input  wire logic        clk_sys_in,          // System clock, 100 MHz
	input  wire logic        reset_in,            // Synchronous reset, active high
	input  wire logic [15:0] ext_irq_in,          // External request pins, unused bits ignored
	input  wire logic        rtc_irq_n_in,        // Real-time clock request, active low
	input  wire logic        coproc_irq_in,       // Coprocessor interface request
	input  wire logic        timer_zero_output_in,// Interval timer counter zero, same clock
	input  wire logic [3:0]  pci_int_n_in,        // PCI interrupt lines, active low
	input  wire logic [15:0] pci_target_in,       // Four 4-bit target codes, 0 disables
	input  wire logic        io_wr_in,            // I/O write strobe
	input  wire logic        io_rd_in,            // I/O read strobe
	input  wire logic [15:0] io_addr_in,          // I/O address
	input  wire logic [7:0]  io_wdata_in,         // I/O write data
	output logic      [7:0]  io_rdata_out,        // I/O read data, one cycle later
	input  wire logic        cfg_wr_in,           // Configuration write strobe
	input  wire logic        cfg_rd_in,           // Configuration read strobe
	input  wire logic [7:0]  cfg_index_in,        // Configuration index
	input  wire logic [7:0]  cfg_wdata_in,        // Configuration write data
	output logic      [7:0]  cfg_rdata_out,       // Configuration read data, one cycle later
	input  wire logic        pci_iack_in,         // PCI interrupt-acknowledge request, level
	output logic             pci_iack_hold_out,   // Bus held while the sequence runs
	output logic             pci_trdy_out,        // One-cycle target ready with vector
	output logic      [7:0]  pci_vector_out,      // Vector returned with target ready
	output logic             cpu_interrupt_request_out // Interrupt request to the processor
);
	// Pin synchronizer, two stages; only stage two is read
	logic [21:0] sync1_r;
	logic [21:0] sync2_r;
	logic [21:0] pins_w;
	logic [15:0] pins_irq;                        // Synchronized request pins
	logic [15:0] pci_irq;                         // Inverted, steered PCI requests
	logic [1:0][7:0] req_vec;                     // Request inputs per controller
	logic [1:0][7:0] elcr_r;                      // Level select per controller
	logic [1:0][7:0] elcr_nxt;
	logic [7:0]  fc1_r;                           // Function control register 1
	logic [7:0]  fc1_nxt;
	logic [3:0]  shptr_r;                         // Shadow read pointer
	logic [3:0]  shptr_nxt;
	logic [7:0]  io_rdata_nxt;
	logic [7:0]  cfg_rdata_nxt;
	logic [1:0]  ack_w;                           // Acknowledge strobes to controllers
	logic [1:0]  int_w;                           // Controller interrupt outputs
	logic [1:0]  top_v;                           // Controller has a pending winner
	logic [1:0][2:0] top_idx;                     // Winning input per controller
	cic_pkg::cic_ctl_t ctl_q [2];                 // Copy of controller state for readback

	// Address match on a command/mask port pair
	function automatic logic port_hit(input logic [15:0] addr, input logic [15:0] base);
		port_hit = (addr[15:1] == base[15:1]);
	endfunction

	// First set bit scanning from highest priority given lowest-priority input
	function automatic logic [3:0] pick(input logic [7:0] vec, input logic [2:0] prio);
		logic [2:0] idx;
		pick = 4'h0;
		for (int k = 0; k < 8; k++) begin
			idx = prio + 3'(k + 1);
			if (vec[idx] && !pick[3]) begin
				pick = {1'b1, idx};
			end
		end
	endfunction

	// Shadow entry with reserved bits forced
	function automatic logic [7:0] shadow_entry(input cic_pkg::cic_ctl_t c, input logic [3:0] e);
		case (e)
			4'h0: shadow_entry = c.init_word_one;
			4'h1: shadow_entry = c.init_word_two;
			4'h2: shadow_entry = c.init_word_three;
			4'h3: shadow_entry = c.init_word_four & cic_pkg::INIT_WORD_FOUR_READ_MASK;
			4'h4: shadow_entry = c.operation_word_two & cic_pkg::OPERATION_WORD_TWO_READ_MASK;
			default: shadow_entry = (c.operation_word_three & cic_pkg::OPERATION_WORD_THREE_READ_MASK)
				| cic_pkg::OPERATION_WORD_THREE_READ_ONES;
		endcase
	endfunction

	assign pins_w = {~pci_int_n_in, coproc_irq_in, ~rtc_irq_n_in, ext_irq_in};

	// Request assembly from synchronized pins and internal sources
	always_comb begin
		pins_irq = sync2_r[15:0];
		pci_irq  = 16'h0000;
		for (int p = 0; p < 4; p++) begin
			// Inverted PCI line ORed onto its target input
			if (sync2_r[18 + p]) begin
				pci_irq[pci_target_in[4*p +: 4]] = 1'b1;
			end
		end
		pci_irq[0] = 1'b0;                        // Code zero means disabled
		req_vec[0] = pins_irq[7:0] | pci_irq[7:0];
		req_vec[0][0] = timer_zero_output_in;
		req_vec[0][cic_pkg::CASCADE_INPUT] = int_w[1];
		req_vec[1] = pins_irq[15:8] | pci_irq[15:8];
		req_vec[1][0] = sync2_r[16];
		req_vec[1][5] = sync2_r[17];
	end

	// Synchronizer registers
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			sync1_r <= 22'h000000;
			sync2_r <= 22'h000000;
		end else begin
			sync1_r <= pins_w;
			sync2_r <= sync1_r;
		end
	end

	// Two controllers from one template, the master's cascade input forced level; index 0 master, 1 slave
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : ctl
			cic_pkg::cic_ctl_t c_r;
			cic_pkg::cic_ctl_t c_nxt;
			logic [7:0]  lvl;                     // Inputs treated as level
			logic [7:0]  ack_clr;
			logic [3:0]  req_pick;
			logic [3:0]  isr_pick;
			logic [2:0]  req_rank;
			logic [2:0]  isr_rank;
			logic [15:0] base;
			logic [7:0]  wd;

			assign base = (g == 0) ? cic_pkg::MASTER_PORT : cic_pkg::SLAVE_PORT;
			assign wd   = io_wdata_in;
			assign req_pick = pick(c_r.irr & ~c_r.imr, c_r.prio);
			assign isr_pick = pick(c_r.isr, c_r.prio);
			assign req_rank = req_pick[2:0] - c_r.prio - 3'h1;
			assign isr_rank = isr_pick[2:0] - c_r.prio - 3'h1;
			// Interrupt only if request outranks anything in service
			assign int_w[g] = c_r.ready && req_pick[3] && (!isr_pick[3] || req_rank < isr_rank);
			assign top_v[g]   = req_pick[3];
			assign top_idx[g] = req_pick[2:0];
			assign ctl_q[g]   = c_r;

			// Request, acknowledge and command word handling
			always_comb begin
				c_nxt = c_r;
				// Global level bit overrides per-input select; cascade input always level
				lvl = c_r.init_word_one[cic_pkg::INIT_LEVEL_BIT] ? 8'hFF : elcr_r[g];
				if (g == 0) begin
					lvl[cic_pkg::CASCADE_INPUT] = 1'b1; // Slave output is a level
				end
				ack_clr = 8'h00;
				if (ack_w[g] && req_pick[3]) begin
					ack_clr[req_pick[2:0]] = 1'b1;
					if (!c_r.init_word_four[cic_pkg::AUTO_EOI_BIT]) begin
						c_nxt.isr[req_pick[2:0]] = 1'b1;
					end
				end
				// New edge wins over an acknowledge clear in the same cycle
				c_nxt.irr  = (lvl & req_vec[g]) | (~lvl & ((c_r.irr & ~ack_clr) | (req_vec[g] & ~c_r.prev)));
				c_nxt.prev = req_vec[g];
				if (io_wr_in && port_hit(io_addr_in, base)) begin
					if (!io_addr_in[0]) begin
						if (wd[4]) begin
							// Word one restarts initialization and clears state
							c_nxt.init_word_one = wd;
							c_nxt.step  = cic_pkg::STEP_WORD2;
							c_nxt.ready = 1'b0;
							c_nxt.imr   = 8'h00;
							c_nxt.isr   = 8'h00;
							c_nxt.irr   = 8'h00;
							c_nxt.prio  = cic_pkg::PRIO_RESET;
							c_nxt.operation_word_three = cic_pkg::OPERATION_WORD_THREE_RESET;
						end else if (c_r.ready && !wd[3]) begin
							c_nxt.operation_word_two = wd;
							case (wd[7:5])
								3'b001: begin // Non-specific end of interrupt
									if (isr_pick[3]) c_nxt.isr[isr_pick[2:0]] = 1'b0;
								end
								3'b011: begin // Specific end of interrupt
									c_nxt.isr[wd[2:0]] = 1'b0;
								end
								3'b101: begin // Rotate on non-specific end
									if (isr_pick[3]) begin
										c_nxt.isr[isr_pick[2:0]] = 1'b0;
										c_nxt.prio = isr_pick[2:0];
									end
								end
								3'b111: begin // Rotate on specific end
									c_nxt.isr[wd[2:0]] = 1'b0;
									c_nxt.prio = wd[2:0];
								end
								3'b110: begin // Set lowest priority
									c_nxt.prio = wd[2:0];
								end
								default: begin // Auto-rotate modes not kept
									c_nxt.prio = c_r.prio;
								end
							endcase
						end else if (c_r.ready) begin
							c_nxt.operation_word_three = wd;
						end
					end else begin
						case (c_r.step)
							cic_pkg::STEP_WORD2: begin
								c_nxt.init_word_two = wd;
								if (!c_r.init_word_one[cic_pkg::INIT_SINGLE_BIT]) begin
									c_nxt.step = cic_pkg::STEP_WORD3;
								end else if (c_r.init_word_one[cic_pkg::INIT_IC4_BIT]) begin
									c_nxt.step = cic_pkg::STEP_WORD4;
								end else begin
									c_nxt.step  = cic_pkg::STEP_NONE;
									c_nxt.ready = 1'b1;
								end
							end
							cic_pkg::STEP_WORD3: begin
								c_nxt.init_word_three = wd;
								if (c_r.init_word_one[cic_pkg::INIT_IC4_BIT]) begin
									c_nxt.step = cic_pkg::STEP_WORD4;
								end else begin
									c_nxt.step  = cic_pkg::STEP_NONE;
									c_nxt.ready = 1'b1;
								end
							end
							cic_pkg::STEP_WORD4: begin
								c_nxt.init_word_four = wd;
								c_nxt.step  = cic_pkg::STEP_NONE;
								c_nxt.ready = 1'b1;
							end
							default: begin // Mask word once running
								if (c_r.ready) c_nxt.imr = wd;
							end
						endcase
					end
				end
			end

			// Controller state register
			always_ff @(posedge clk_sys_in) begin
				if (reset_in) begin
					c_r <= '{init_word_one: 8'h00, init_word_two: 8'h00, init_word_three: 8'h00,
						init_word_four: 8'h00, operation_word_two: 8'h00,
						operation_word_three: cic_pkg::OPERATION_WORD_THREE_RESET, imr: 8'h00, irr: 8'h00,
						isr: 8'h00, prev: 8'h00, prio: cic_pkg::PRIO_RESET,
						step: cic_pkg::STEP_NONE, ready: 1'b0};
				end else begin
					c_r <= c_nxt;
				end
			end
		end
	endgenerate

	// Acknowledge sequencer state
	cic_pkg::cic_ack_t st_r;
	cic_pkg::cic_ack_t st_nxt;
	logic       casc_r;                           // Slave supplies the vector
	logic       casc_nxt;
	logic [3:0] mpick_r;                          // Master winner with valid flag
	logic [3:0] mpick_nxt;
	logic [3:0] spick_r;                          // Slave winner with valid flag
	logic [3:0] spick_nxt;
	logic [7:0] vec_nxt;
	logic       trdy_nxt;
	logic       hold_nxt;

	// Bus acknowledge runs both internal cycles, then target ready
	always_comb begin
		st_nxt    = st_r;
		casc_nxt  = casc_r;
		mpick_nxt = mpick_r;
		spick_nxt = spick_r;
		vec_nxt   = pci_vector_out;
		trdy_nxt  = 1'b0;
		hold_nxt  = pci_iack_hold_out;
		ack_w     = 2'b00;
		case (st_r)
			cic_pkg::ACK_IDLE: begin
				if (pci_iack_in && fc1_r[cic_pkg::IACK_EN_BIT]) begin
					st_nxt   = cic_pkg::ACK_FIRST;
					hold_nxt = 1'b1;
				end
			end
			cic_pkg::ACK_FIRST: begin
				// Cascade decision from master word three
				ack_w[0]  = 1'b1;
				casc_nxt  = top_v[0] && ctl_q[0].init_word_three[top_idx[0]];
				ack_w[1]  = casc_nxt;
				mpick_nxt = {top_v[0], top_idx[0]};
				spick_nxt = {top_v[1], top_idx[1]};
				st_nxt    = cic_pkg::ACK_SECND;
			end
			cic_pkg::ACK_SECND: begin
				// Vector base plus winning input, spurious input seven if none
				if (casc_r) begin
					vec_nxt = {ctl_q[1].init_word_two[7:3],
						spick_r[3] ? spick_r[2:0] : cic_pkg::SPURIOUS_IDX[2:0]};
				end else begin
					vec_nxt = {ctl_q[0].init_word_two[7:3],
						mpick_r[3] ? mpick_r[2:0] : cic_pkg::SPURIOUS_IDX[2:0]};
				end
				trdy_nxt = 1'b1;
				st_nxt   = cic_pkg::ACK_DONE;
			end
			default: begin
				hold_nxt = 1'b0;
				st_nxt   = cic_pkg::ACK_IDLE;
			end
		endcase
	end

	// Register-file and shadow next values
	always_comb begin
		elcr_nxt      = elcr_r;
		fc1_nxt       = fc1_r;
		shptr_nxt     = shptr_r;
		io_rdata_nxt  = 8'h00;
		cfg_rdata_nxt = 8'h00;
		if (io_wr_in && io_addr_in == cic_pkg::SENSE_LO_PORT) begin
			elcr_nxt[0] = io_wdata_in & cic_pkg::SENSE_LO_MASK;
		end else if (io_wr_in && io_addr_in == cic_pkg::SENSE_HI_PORT) begin
			elcr_nxt[1] = io_wdata_in & cic_pkg::SENSE_HI_MASK;
		end
		if (io_rd_in) begin
			if (io_addr_in == cic_pkg::SENSE_LO_PORT) begin
				io_rdata_nxt = elcr_r[0];
			end else if (io_addr_in == cic_pkg::SENSE_HI_PORT) begin
				io_rdata_nxt = elcr_r[1];
			end else if (port_hit(io_addr_in, cic_pkg::MASTER_PORT) || port_hit(io_addr_in, cic_pkg::SLAVE_PORT)) begin
				// Odd port mask, even port request or in-service per word three
				for (int i = 0; i < 2; i++) begin
					if (port_hit(io_addr_in, i == 0 ? cic_pkg::MASTER_PORT : cic_pkg::SLAVE_PORT)) begin
						if (io_addr_in[0]) begin
							io_rdata_nxt = ctl_q[i].imr;
						end else if (ctl_q[i].operation_word_three[0]) begin
							io_rdata_nxt = ctl_q[i].isr;
						end else begin
							io_rdata_nxt = ctl_q[i].irr;
						end
					end
				end
			end
		end
		if (cfg_wr_in && cfg_index_in == cic_pkg::FUNC_CTL1_IDX) begin
			fc1_nxt = cfg_wdata_in;
		end else if (cfg_wr_in && cfg_index_in == cic_pkg::SHADOW_IDX) begin
			shptr_nxt = 4'h0;
		end
		if (cfg_rd_in && cfg_index_in == cic_pkg::FUNC_CTL1_IDX) begin
			cfg_rdata_nxt = fc1_r;
		end else if (cfg_rd_in && cfg_index_in == cic_pkg::SHADOW_IDX) begin
			// Master six entries first, then slave six
			if (shptr_r < cic_pkg::SHADOW_PER_CTL) begin
				cfg_rdata_nxt = shadow_entry(ctl_q[0], shptr_r);
			end else begin
				cfg_rdata_nxt = shadow_entry(ctl_q[1], shptr_r - cic_pkg::SHADOW_PER_CTL);
			end
			shptr_nxt = (shptr_r == cic_pkg::SHADOW_LAST) ? 4'h0 : shptr_r + 4'h1;
		end
	end

	// Registers of sequencer, register file and outputs
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			st_r           <= cic_pkg::ACK_IDLE;
			casc_r         <= 1'b0;
			mpick_r        <= 4'h0;
			spick_r        <= 4'h0;
			pci_vector_out <= 8'h00;
			pci_trdy_out   <= 1'b0;
			pci_iack_hold_out <= 1'b0;
			elcr_r         <= '0;
			fc1_r          <= cic_pkg::FUNC_CTL1_RST;
			shptr_r        <= 4'h0;
			io_rdata_out   <= 8'h00;
			cfg_rdata_out  <= 8'h00;
			cpu_interrupt_request_out <= 1'b0;
		end else begin
			st_r           <= st_nxt;
			casc_r         <= casc_nxt;
			mpick_r        <= mpick_nxt;
			spick_r        <= spick_nxt;
			pci_vector_out <= vec_nxt;
			pci_trdy_out   <= trdy_nxt;
			pci_iack_hold_out <= hold_nxt;
			elcr_r         <= elcr_nxt;
			fc1_r          <= fc1_nxt;
			shptr_r        <= shptr_nxt;
			io_rdata_out   <= io_rdata_nxt;
			cfg_rdata_out  <= cfg_rdata_nxt;
			cpu_interrupt_request_out <= int_w[0];
		end
	end
endmodule
